/* File: hdl/assc_pkg.sv */
// Purpose: Shared constants and types for the serial channel
// Assumes: 100 MHz ref_clk, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
package assc_pkg;

  // Clock rate of ref_clk
  localparam int unsigned CLK_HZ = 100_000_000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_TXBUF = 8'h08;
  localparam logic [7:0] OFS_RXBUF = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // Control field positions
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_NINE = 1;
  localparam int CTRL_PAR_EN = 2;
  localparam int CTRL_PAR_ODD = 3;
  localparam int CTRL_STOP2 = 4;
  localparam int CTRL_WAKE = 5;
  localparam int CTRL_FE_EN = 6;
  localparam int CTRL_OE_EN = 7;
  localparam int CTRL_LOOP = 8;
  localparam int CTRL_REN = 9;
  localparam int CTRL_RUN = 10;
  localparam int CTRL_W = 11;

  // Status and mask field positions
  localparam int ST_TX = 0;
  localparam int ST_TBUF = 1;
  localparam int ST_RX = 2;
  localparam int ST_ERR = 3;
  localparam int ST_PE = 4;
  localparam int ST_FE = 5;
  localparam int ST_OE = 6;
  localparam int STAT_W = 7;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [12:0] BAUD_RST = 13'h0000;
  localparam logic [STAT_W-1:0] STAT_RST = 7'h00;
  localparam logic [8:0] BUF_RST = 9'h000;

  // Timing counts in baud ticks and frame bits
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] RX_MID = 4'h7;
  localparam logic [1:0] SYNC_RISE = 2'h1;
  localparam logic [1:0] SYNC_FALL = 2'h3;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] ASYNC_BASE = 4'ha;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Receiver states, Gray along the frame
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } assc_rx_state_t;

  // Shift engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ASYNC = 2'b01,
    ENG_SYNC = 2'b11
  } assc_eng_state_t;

endpackage

/* File: hdl/assc_rx_if.sv */
// Purpose: Bundle between the channel core and its async receiver
// Assumes: One clock domain
// Notes: Config in, frame results out
`timescale 1ns/1ps
interface assc_rx_if;
  logic tick; // Oversample tick
  logic en; // Receiver enabled
  logic nine; // Nine data bits
  logic par_en; // Ninth bit is parity
  logic par_odd; // Odd parity
  logic fe_en; // Stop bit check
  logic line; // Serial input level
  logic done; // Frame complete pulse
  logic [8:0] data; // Received bits
  logic perr; // Parity mismatch
  logic ferr; // Missing stop bit
  modport ctl(output tick, en, nine, par_en, par_odd, fe_en, line, input done, data, perr, ferr);
  modport rx(input tick, en, nine, par_en, par_odd, fe_en, line, output done, data, perr, ferr);
endinterface

/* File: hdl/assc_baud.sv */
// Purpose: Baud tick generator
// Assumes: reload stable while run
// Notes: Tick period is 2*(reload+1) ref_clk cycles
`timescale 1ns/1ps
module assc_baud
  import assc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [12:0] reload,
  output logic tick
);

  logic [13:0] cnt_reg; // Down counter

  // Reload on zero, so every rate is a plain divisor
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 14'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= {reload, 1'b1};
      tick <= 1'b0;
    end else if (cnt_reg == 14'h0000) begin
      cnt_reg <= {reload, 1'b1};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 14'h0001;
      tick <= 1'b0;
    end
  end

endmodule // assc_baud

/* File: hdl/assc_rx.sv */
// Purpose: Asynchronous frame receiver, 16x oversampled
// Assumes: line already synchronous to ref_clk
// Notes: Only the first stop bit is checked
`timescale 1ns/1ps
module assc_rx
  import assc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  assc_rx_if.rx rxi
);

  assc_rx_state_t state_reg; // Frame position
  logic [3:0] cnt_reg; // Ticks within bit
  logic [3:0] bitn_reg; // Data bit index
  logic [8:0] sh_reg; // Shift in from the top
  logic done_reg;
  logic [8:0] data_reg;
  logic perr_reg;
  logic ferr_reg;
  logic [3:0] last_bit; // Index of final data bit
  logic prev_line_reg; // Line level one clock ago

  assign last_bit = rxi.nine ? 4'h8 : 4'h7;
  assign rxi.done = done_reg;
  assign rxi.data = data_reg;
  assign rxi.perr = perr_reg;
  assign rxi.ferr = ferr_reg;

  // Frame walker; each bit sampled at its middle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RX_IDLE;
      cnt_reg <= 4'h0;
      bitn_reg <= 4'h0;
      sh_reg <= BUF_RST;
      done_reg <= 1'b0;
      data_reg <= BUF_RST;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      prev_line_reg <= 1'b1; // Idle level, so no false edge after reset
    end else begin
      done_reg <= 1'b0;
      // A low stop bit must not look like the next start bit
      prev_line_reg <= rxi.line;
      case (state_reg)
        RX_IDLE: begin
          // Falling edge marks a possible start bit
          if (rxi.en && prev_line_reg && !rxi.line) begin
            state_reg <= RX_START;
            cnt_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (!rxi.en) begin
            state_reg <= RX_IDLE;
          end else if (rxi.tick) begin
            if (cnt_reg == RX_MID) begin
              // Glitch shorter than half a bit is dropped
              state_reg <= rxi.line ? RX_IDLE : RX_DATA;
              cnt_reg <= 4'h0;
              bitn_reg <= 4'h0;
            end else begin
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (rxi.tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == OVS_LAST) begin
              sh_reg <= {rxi.line, sh_reg[8:1]};
              bitn_reg <= bitn_reg + 4'h1;
              if (bitn_reg == last_bit) begin
                state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (rxi.tick) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == OVS_LAST) begin
              state_reg <= RX_IDLE;
              done_reg <= 1'b1;
              data_reg <= rxi.nine ? sh_reg : {1'b0, sh_reg[8:1]};
              perr_reg <= rxi.par_en && rxi.nine && ((^sh_reg) ^ rxi.par_odd);
              ferr_reg <= rxi.fe_en && !rxi.line;
            end
          end
        end
        default: begin
          state_reg <= RX_IDLE;
        end
      endcase
    end
  end

endmodule // assc_rx

/* File: hdl/assc_top.sv */
// Purpose: Async/sync serial channel with AXI4-Lite registers
// Assumes: Pins synchronous to ref_clk; one AXI write and one read at a time
// Notes: Async bit = 32*(baud+1) clocks, sync bit = 8*(baud+1) clocks
`timescale 1ns/1ps
module assc_top
  import assc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd_out,
  input wire logic sdat_in,
  output logic sdat_out,
  output logic sdat_oe,
  output logic irq,
  output logic irq_tx,
  output logic irq_tbuf,
  output logic irq_rx,
  output logic irq_err
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] aw_addr_reg; // Held write address
  logic [31:0] w_data_reg; // Held write data
  logic [3:0] w_strb_reg; // Held byte enables
  logic wr_fire; // Both halves present
  logic wr_known; // Write address decodes
  logic [15:0] wr_low; // Lane-merged low half, base zero
  logic [CTRL_W-1:0] ctrl_reg; // Mode and enables
  logic [12:0] baud_reg; // Baud reload
  logic [8:0] txbuf_reg; // Transmit buffer
  logic txbuf_full_reg; // Buffer awaits the engine
  logic [8:0] rxbuf_reg; // Receive buffer
  logic rx_full_reg; // Buffer unread
  logic [STAT_W-1:0] stat_reg; // Sticky events
  logic [STAT_W-1:0] mask_reg; // Interrupt enables
  logic [STAT_W-1:0] stat_set; // Events this cycle
  logic [31:0] rd_data; // Read mux
  logic rd_known; // Read address decodes
  logic rd_fire; // Read taken
  logic tick; // Baud tick
  assc_eng_state_t eng_reg; // Shift engine
  logic [11:0] sh_reg; // Outgoing frame
  logic [3:0] left_reg; // Bits still to go
  logic [3:0] ph_reg; // Ticks within bit
  logic srx_reg; // Sync engine receiving
  logic [7:0] rsh_reg; // Sync receive shift
  logic tx_done_reg; // Frame finished pulse
  logic tbuf_take_reg; // Buffer taken pulse
  logic sync_rdone_reg; // Sync byte in pulse
  logic sync_bit; // Sync input source
  logic [8:0] txd_bits; // Ninth bit resolved
  logic async_ok; // Async frame accepted
  logic rx_evt; // Any character accepted
  logic [8:0] rx_word; // Character to store
  logic overrun; // Unread data overwritten

  assc_rx_if rxi ();

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_known = (aw_addr_reg == OFS_CTRL) || (aw_addr_reg == OFS_BAUD) || (aw_addr_reg == OFS_TXBUF)
    || (aw_addr_reg == OFS_STAT) || (aw_addr_reg == OFS_MASK);
  // Unwritten lanes read as zero here, callers merge old values
  assign wr_low = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00, w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};

  // Address channel; ready drops once held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel; may arrive before or after the address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response one cycle after both halves held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux, reserved bits zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL: rd_data[CTRL_W-1:0] = ctrl_reg;
      OFS_BAUD: rd_data[12:0] = baud_reg;
      OFS_TXBUF: rd_data[8:0] = txbuf_reg;
      OFS_RXBUF: rd_data[8:0] = rxbuf_reg;
      OFS_STAT: rd_data[STAT_W-1:0] = stat_reg;
      OFS_MASK: rd_data[STAT_W-1:0] = mask_reg;
      default: rd_known = 1'b0;
    endcase
  end

  // Read data registered at the address handshake
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Control, baud and mask; reset leaves everything idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
      mask_reg <= STAT_RST;
    end else if (wr_fire) begin
      if (aw_addr_reg == OFS_CTRL) begin
        ctrl_reg[7:0] <= w_strb_reg[0] ? wr_low[7:0] : ctrl_reg[7:0];
        ctrl_reg[CTRL_W-1:8] <= w_strb_reg[1] ? wr_low[CTRL_W-1:8] : ctrl_reg[CTRL_W-1:8];
      end
      if (aw_addr_reg == OFS_BAUD) begin
        baud_reg[7:0] <= w_strb_reg[0] ? wr_low[7:0] : baud_reg[7:0];
        baud_reg[12:8] <= w_strb_reg[1] ? wr_low[12:8] : baud_reg[12:8];
      end
      if (aw_addr_reg == OFS_MASK && w_strb_reg[0]) begin
        mask_reg <= wr_low[STAT_W-1:0];
      end
    end
  end

  // Transmit buffer; a new write wins over the engine taking it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txbuf_reg <= BUF_RST;
      txbuf_full_reg <= 1'b0;
    end else if (wr_fire && aw_addr_reg == OFS_TXBUF && w_strb_reg[0]) begin
      txbuf_reg <= {w_strb_reg[1] ? wr_low[8] : txbuf_reg[8], wr_low[7:0]};
      txbuf_full_reg <= 1'b1;
    end else if (tbuf_take_reg) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator and async receiver

  assc_baud u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(ctrl_reg[CTRL_RUN]),
    .reload(baud_reg),
    .tick(tick)
  );

  assign rxi.tick = tick;
  // Receiver is blocked in sync mode, the data pin is shared there
  assign rxi.en = ctrl_reg[CTRL_RUN] && ctrl_reg[CTRL_REN] && !ctrl_reg[CTRL_SYNC];
  assign rxi.nine = ctrl_reg[CTRL_NINE];
  assign rxi.par_en = ctrl_reg[CTRL_PAR_EN];
  assign rxi.par_odd = ctrl_reg[CTRL_PAR_ODD];
  assign rxi.fe_en = ctrl_reg[CTRL_FE_EN];
  assign rxi.line = ctrl_reg[CTRL_LOOP] ? txd_out : sdat_in;

  assc_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .rxi(rxi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine: async transmit or sync byte either way

  // Ninth bit is parity or the software wake-up bit
  assign txd_bits = {ctrl_reg[CTRL_PAR_EN] ? ((^txbuf_reg[7:0]) ^ ctrl_reg[CTRL_PAR_ODD]) : txbuf_reg[8],
    txbuf_reg[7:0]};
  assign sync_bit = ctrl_reg[CTRL_LOOP] ? sdat_out : sdat_in;

  // One engine serves both modes; the async receiver runs beside it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eng_reg <= ENG_IDLE;
      sh_reg <= 12'hfff;
      left_reg <= 4'h0;
      ph_reg <= 4'h0;
      srx_reg <= 1'b0;
      rsh_reg <= 8'h00;
      txd_out <= 1'b1;
      sdat_out <= 1'b1;
      sdat_oe <= 1'b0;
      tx_done_reg <= 1'b0;
      tbuf_take_reg <= 1'b0;
      sync_rdone_reg <= 1'b0;
    end else begin
      tx_done_reg <= 1'b0;
      tbuf_take_reg <= 1'b0;
      sync_rdone_reg <= 1'b0;
      case (eng_reg)
        ENG_IDLE: begin
          txd_out <= 1'b1;
          sdat_oe <= 1'b0;
          ph_reg <= 4'h0;
          if (ctrl_reg[CTRL_RUN] && txbuf_full_reg && !tbuf_take_reg && !ctrl_reg[CTRL_SYNC]) begin
            // Start bit now, frame bits follow from bit 1
            eng_reg <= ENG_ASYNC;
            sh_reg <= ctrl_reg[CTRL_NINE] ? {2'b11, txd_bits, 1'b0} : {3'b111, txd_bits[7:0], 1'b0};
            left_reg <= ASYNC_BASE + {3'b000, ctrl_reg[CTRL_NINE]} + {3'b000, ctrl_reg[CTRL_STOP2]};
            txd_out <= 1'b0;
            tbuf_take_reg <= 1'b1;
          end else if (ctrl_reg[CTRL_RUN] && ctrl_reg[CTRL_SYNC] && txbuf_full_reg && !tbuf_take_reg && tick) begin
            // Sync transmit drives the data pin, shift clock goes low on a tick so its low half is whole
            eng_reg <= ENG_SYNC;
            srx_reg <= 1'b0;
            sh_reg <= {4'hf, txbuf_reg[7:0]};
            left_reg <= SYNC_BITS;
            sdat_out <= txbuf_reg[0];
            sdat_oe <= 1'b1;
            txd_out <= 1'b0;
            tbuf_take_reg <= 1'b1;
          end else if (ctrl_reg[CTRL_RUN] && ctrl_reg[CTRL_SYNC] && ctrl_reg[CTRL_REN] && tick) begin
            // Sync receive only while nothing is queued to send
            eng_reg <= ENG_SYNC;
            srx_reg <= 1'b1;
            left_reg <= SYNC_BITS;
            sdat_out <= 1'b1;
            txd_out <= 1'b0;
          end
        end
        ENG_ASYNC: begin
          if (tick) begin
            ph_reg <= ph_reg + 4'h1;
            if (ph_reg == OVS_LAST) begin
              sh_reg <= {1'b1, sh_reg[11:1]};
              left_reg <= left_reg - 4'h1;
              if (left_reg == 4'h1) begin
                eng_reg <= ENG_IDLE;
                txd_out <= 1'b1;
                tx_done_reg <= 1'b1;
              end else begin
                txd_out <= sh_reg[1];
              end
            end
          end
        end
        ENG_SYNC: begin
          if (tick) begin
            ph_reg <= {2'b00, ph_reg[1:0] + 2'h1};
            if (ph_reg[1:0] == SYNC_RISE) begin
              // Rising shift clock; partner and we latch here
              txd_out <= 1'b1;
              rsh_reg <= {sync_bit, rsh_reg[7:1]};
            end else if (ph_reg[1:0] == SYNC_FALL) begin
              left_reg <= left_reg - 4'h1;
              sh_reg <= {1'b1, sh_reg[11:1]};
              if (left_reg == 4'h1) begin
                // Clock parks high after the eighth bit
                eng_reg <= ENG_IDLE;
                sdat_oe <= 1'b0;
                tx_done_reg <= !srx_reg;
                sync_rdone_reg <= srx_reg;
              end else begin
                txd_out <= 1'b0;
                sdat_out <= srx_reg ? 1'b1 : sh_reg[1];
              end
            end
          end
        end
        default: begin
          eng_reg <= ENG_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and events

  // Address frames only, while wake-up filtering is on with nine data bits
  assign async_ok = rxi.done && !(ctrl_reg[CTRL_WAKE] && ctrl_reg[CTRL_NINE] && !rxi.data[8]);
  assign rx_evt = async_ok || sync_rdone_reg;
  assign rx_word = sync_rdone_reg ? {1'b0, rsh_reg} : rxi.data;
  assign overrun = rx_evt && rx_full_reg && ctrl_reg[CTRL_OE_EN];

  // A new character landing in the reading cycle keeps the buffer full
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxbuf_reg <= BUF_RST;
      rx_full_reg <= 1'b0;
    end else if (rx_evt) begin
      rxbuf_reg <= rx_word;
      rx_full_reg <= 1'b1;
    end else if (rd_fire && s_axi_araddr == OFS_RXBUF) begin
      rx_full_reg <= 1'b0;
    end
  end

  always_comb begin
    stat_set = STAT_RST;
    stat_set[ST_TX] = tx_done_reg;
    stat_set[ST_TBUF] = tbuf_take_reg;
    stat_set[ST_RX] = rx_evt;
    stat_set[ST_PE] = async_ok && rxi.perr;
    stat_set[ST_FE] = async_ok && rxi.ferr;
    stat_set[ST_OE] = overrun;
    stat_set[ST_ERR] = stat_set[ST_PE] || stat_set[ST_FE] || overrun;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= STAT_RST;
    end else if (wr_fire && aw_addr_reg == OFS_STAT && w_strb_reg[0]) begin
      stat_reg <= (stat_reg & ~wr_low[STAT_W-1:0]) | stat_set;
    end else begin
      stat_reg <= stat_reg | stat_set;
    end
  end

  // Four request lines plus their union, all registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_tx <= 1'b0;
      irq_tbuf <= 1'b0;
      irq_rx <= 1'b0;
      irq_err <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_tx <= stat_reg[ST_TX] && mask_reg[ST_TX];
      irq_tbuf <= stat_reg[ST_TBUF] && mask_reg[ST_TBUF];
      irq_rx <= stat_reg[ST_RX] && mask_reg[ST_RX];
      irq_err <= |(stat_reg[ST_OE:ST_ERR] & mask_reg[ST_OE:ST_ERR]);
      irq <= |(stat_reg & mask_reg);
    end
  end

endmodule // assc_top

/* File: verification/assc_assertions.sv */
// Purpose: Port checks for the serial channel
// Assumes: Bound to assc_top
// Notes: Bus answer and pin timing
`timescale 1ns/1ps
module assc_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic txd_out,
  input wire logic sdat_out,
  input wire logic sdat_oe,
  input wire logic irq,
  input wire logic irq_tx,
  input wire logic irq_tbuf,
  input wire logic irq_rx,
  input wire logic irq_err
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  idle_out_a: assert property ($fell(rst) |-> txd_out && !sdat_oe && !irq)
    else $error("not idle after reset");
  irq_sum_a: assert property (irq == (irq_tx | irq_tbuf | irq_rx | irq_err))
    else $error("summary irq differs");
  low_min_a: assert property ($fell(txd_out) |-> !txd_out [*4])
    else $error("line low too short");
  sync_edge_a: assert property (sdat_oe && $past(sdat_oe) && $changed(sdat_out) |-> $fell(txd_out))
    else $error("data moved off clock fall");
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("no read answer");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address not refused");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read answer without request");
endmodule // assc_assertions

/* File: verification/assc_partner.sv */
// Purpose: Remote async transceiver on the line side
// Assumes: Eight data bits, fixed bit time
// Notes: Ninth bit and stops are not captured
`timescale 1ns/1ps
module assc_partner #(parameter int BIT = 32) (
  input wire logic ref_clk,
  input wire logic rx_line,
  output logic tx_line,
  output logic [7:0] got
);
  // Start, byte least bit first, chosen stop level
  task automatic send(input logic [7:0] b, input logic stp);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      tx_line <= (i == 0) ? 1'b0 : ((i == 9) ? stp : b[i-1]);
      repeat (BIT - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    tx_line <= 1'b1;
  endtask
  // Idle high; sample each bit at its middle
  initial begin
    tx_line = 1'b1;
    got = 8'h00;
    forever begin
      @(negedge rx_line);
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        got = {rx_line, got[7:1]};
      end
    end
  end
endmodule // assc_partner

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the serial channel
// Assumes: BAUD zero, so 32 clocks a bit
// Notes: Rows cover frame formats, tails cover errors
`timescale 1ns/1ps
module tb;
  import assc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, pc;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got, d, sb;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf, iv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sdat_in;
  logic txd_out, sdat_out, sdat_oe, irq, irq_tx, irq_tbuf, irq_rx, irq_err;
  logic [10:0] c;
  logic [8:0] e;
  logic [6:0] s;
  int err_count = 0, n_checks = 0, n;
  // Control, byte, receive buffer, status
  logic [34:0] rows [6] = '{{11'h6c0, 8'h55, 9'h055, 7'h07}, {11'h6d0, 8'ha3, 9'h0a3, 7'h07},
    {11'h6e2, 8'h3c, 9'h13c, 7'h07}, {11'h6c6, 8'h01, 9'h101, 7'h07},
    {11'h6c6, 8'h03, 9'h103, 7'h1f}, {11'h6ce, 8'h03, 9'h103, 7'h07}};
  assign iv = {irq_err, irq_rx, irq_tbuf, irq_tx};
  always #5 ref_clk = ~ref_clk;
  assc_top u_dut (.*);
  assc_partner u_far (.ref_clk(ref_clk), .rx_line(txd_out), .tx_line(sdat_in), .got(got));
  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] x);
    n_checks++;
    if (a !== x) begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, a, x);
    end
  endtask
  // A used-up bound ends the run
  task automatic to(input int i);
    if (i >= 900) begin
      err_count++;
      results();
    end
  endtask
  // Ready is held back a little so the slave must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 900; i++) begin
      @(posedge ref_clk);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= (i > 1);
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    to(i);
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 900; i++) begin
      @(posedge ref_clk);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= (i > 0);
    end
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    to(i);
  endtask
  task automatic wi(input int k);
    int i;
    for (i = 0; i < 900 && iv[k] !== 1'b1; i++) @(posedge ref_clk);
    to(i);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    chk(txd_out, 32'h1);
    rd(OFS_CTRL);
    chk(rv, 32'h0);
    rd(8'h18);
    chk(rr, RESP_SLVERR);
    wr(OFS_MASK, 32'h7f);
    // Both directions at once in each format
    for (int k = 0; k < 6; k++) begin
      {c, d, e, s} = rows[k];
      wr(OFS_CTRL, 32'(c));
      fork
        u_far.send(d, 1'b1);
        wr(OFS_TXBUF, 32'(d));
      join
      wi(0);
      wi(2);
      chk(iv, s[3:0]);
      chk(got, d);
      rd(OFS_STAT);
      chk(rv, s);
      rd(OFS_RXBUF);
      chk(rv, e);
      wr(OFS_STAT, 32'h7f);
    end
    // Wake-up filter drops a frame whose ninth bit is low
    wr(OFS_CTRL, 32'h6e2);
    u_far.send(8'h5a, 1'b0);
    repeat (40) @(posedge ref_clk);
    rd(OFS_STAT);
    chk(rv, 32'h0);
    // Overrun, then masking of the error line
    wr(OFS_CTRL, 32'h6c0);
    wr(OFS_MASK, 32'h04);
    u_far.send(8'h11, 1'b1);
    wi(2);
    u_far.send(8'h22, 1'b1);
    rd(OFS_STAT);
    chk(rv, 32'h4c);
    chk({irq, irq_err}, 32'h2);
    rd(OFS_RXBUF);
    chk(rv, 32'h22);
    wr(OFS_STAT, 32'h7f);
    u_far.send(8'h33, 1'b0);
    rd(OFS_STAT);
    chk(rv, 32'h2c);
    wr(OFS_STAT, 32'h20);
    rd(OFS_STAT);
    chk(rv, 32'h0c);
    wr(OFS_STAT, 32'h7f);
    chk(irq, 32'h0);
    wr(OFS_CTRL, 32'h700);
    wr(OFS_TXBUF, 32'h96);
    wi(2);
    rd(OFS_RXBUF);
    chk(rv, 32'h96);
    // Sync send: take data on each clock rise
    wr(OFS_CTRL, 32'h401);
    wr(OFS_TXBUF, 32'hc5);
    n = 0;
    pc = 1'b1;
    for (int i = 0; i < 900 && n < 8; i++) begin
      @(posedge ref_clk);
      if (sdat_oe && !pc && txd_out) begin
        sb = {sdat_out, sb[7:1]};
        n++;
      end
      pc = txd_out;
    end
    if (n < 8) to(900);
    chk(sb, 32'hc5);
    // Sync receive: partner holds its line low, bytes arrive as zero
    wr(OFS_STAT, 32'h7f);
    wr(OFS_CTRL, 32'h601);
    fork
      u_far.send(8'h00, 1'b0);
      begin
        wi(2);
        chk(sdat_oe, 32'h0);
        rd(OFS_RXBUF);
      end
    join
    chk(rv, 32'h0);
    results();
  end
endmodule // tb
bind assc_top assc_assertions u_chk (.*);
